// file: sdsl_synth.v
// digital section of an integer-n synthesizer: serial load, latches,
// dual-modulus feedback divider, reference divider, power-down, observe mux
// assumes every pin input is asynchronous to clk_sys; vco and reference
// inputs are sampled here, so they must stay well below clk_sys / 2
`timescale 1ns/1ps
`include "sdsl_consts.vh"

module sdsl_synth #(
    parameter WORD_W = `SDSL_WORD_W
) (
    input  wire clk_sys,
    input  wire reset_n,
    input  wire serialClock,
    input  wire serialData,
    input  wire load_strobe,
    input  wire chipEnable,
    input  wire reference_input,
    input  wire vcoInput,
    input  wire lockDetectIn,
    output reg  observe_output,
    output reg  pumpOutputEnable,
    output reg  ref_series_switch_a,
    output reg  ref_series_switch_b,
    output reg  ref_shunt_switch,
    output reg  powerDown
);

    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    reg [1:0] rstSync_q;
    wire      rst_n = rstSync_q[1];

    always @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rstSync_q <= 2'h0;
        end else begin
            rstSync_q <= {rstSync_q[0], 1'b1};
        end
    end

    // stage 0 and 1 synchronise; stage 2 only feeds edge detection
    reg [2:0] sclk_q, strb_q, ref_q, vco_q;
    reg [1:0] data_q, ce_q, lock_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sclk_q <= 3'h0;
            strb_q <= 3'h0;
            ref_q  <= 3'h0;
            vco_q  <= 3'h0;
            data_q <= 2'h0;
            ce_q   <= 2'h0;
            lock_q <= 2'h0;
        end else begin
            sclk_q <= {sclk_q[1:0], serialClock};
            strb_q <= {strb_q[1:0], load_strobe};
            ref_q  <= {ref_q[1:0], reference_input};
            vco_q  <= {vco_q[1:0], vcoInput};
            data_q <= {data_q[0], serialData};
            ce_q   <= {ce_q[0], chipEnable};
            lock_q <= {lock_q[0], lockDetectIn};
        end
    end

    wire sclkRise = sclk_q[1] & ~sclk_q[2];
    wire strbRise = strb_q[1] & ~strb_q[2];
    wire refRise  = ref_q[1] & ~ref_q[2];
    wire vcoRise  = vco_q[1] & ~vco_q[2];

    // ----------------------------------------------------------------
    // shift register and latches
    // ----------------------------------------------------------------
    reg [WORD_W-1:0] shift_q;
    reg [WORD_W-1:0] ctrlLatch_q, refLatch_q, fbLatch_q, testLatch_q;
    wire [1:0] latchSel = {shift_q[`SDSL_SEL_HI], shift_q[`SDSL_SEL_LO]};

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            shift_q     <= `SDSL_RST_WORD;
            ctrlLatch_q <= `SDSL_RST_WORD;
            refLatch_q  <= `SDSL_RST_WORD;
            fbLatch_q   <= `SDSL_RST_WORD;
            testLatch_q <= `SDSL_RST_WORD;
        end else begin
            if (sclkRise) begin
                shift_q <= {shift_q[WORD_W-2:0], data_q[1]};
            end
            if (strbRise) begin
                case (latchSel)
                    `SDSL_SEL_CONTROL:  ctrlLatch_q <= shift_q;
                    `SDSL_SEL_REFDIV:   refLatch_q  <= shift_q;
                    `SDSL_SEL_FEEDBACK: fbLatch_q   <= shift_q;
                    // test latch is kept but steers nothing
                    default:            testLatch_q <= shift_q;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // decoded settings
    // ----------------------------------------------------------------
    wire [1:0]  preSel  = ctrlLatch_q[`SDSL_PRE_HI:`SDSL_PRE_LO];
    wire [2:0]  muxSel  = ctrlLatch_q[`SDSL_MUX_HI:`SDSL_MUX_LO];
    wire        cntHold = ctrlLatch_q[`SDSL_CRESET_BIT];
    wire [12:0] bPreset = fbLatch_q[`SDSL_B_HI:`SDSL_B_LO];
    wire [4:0]  aPreset = fbLatch_q[`SDSL_A_HI:`SDSL_A_LO];
    wire [13:0] rPreset = refLatch_q[`SDSL_R_HI:`SDSL_R_LO];

    // 11 also gives 32/33: the setting has no other meaning here
    function [5:0] modulus;
        input [1:0] sel;
        begin
            case (sel)
                `SDSL_PRE_8:  modulus = `SDSL_MOD_8;
                `SDSL_PRE_16: modulus = `SDSL_MOD_16;
                default:      modulus = `SDSL_MOD_32;
            endcase
        end
    endfunction

    wire powerDown_d = ~ce_q[1] | ctrlLatch_q[`SDSL_PD1_BIT];
    wire divHold     = powerDown_d | cntHold;

    // ----------------------------------------------------------------
    // feedback divider: prescaler with a and b counters
    // ----------------------------------------------------------------
    reg [5:0]  preCnt_q;
    reg [4:0]  aCnt_q;
    reg [12:0] bCnt_q;
    reg        fbPulse_q;
    wire [5:0] curMod  = (aCnt_q != 5'h00) ? modulus(preSel) + 6'h01
                                           : modulus(preSel);
    // >= so a smaller modulus written mid-count cannot run past the compare
    wire       preOut  = vcoRise & (preCnt_q >= curMod - 6'h01);

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            preCnt_q  <= 6'h00;
            aCnt_q    <= 5'h00;
            bCnt_q    <= `SDSL_RST_B;
            fbPulse_q <= 1'b0;
        end else if (divHold) begin
            preCnt_q  <= 6'h00;
            aCnt_q    <= aPreset;
            bCnt_q    <= bPreset;
            fbPulse_q <= 1'b0;
        end else begin
            fbPulse_q <= 1'b0;
            if (vcoRise) begin
                preCnt_q <= preOut ? 6'h00 : preCnt_q + 6'h01;
            end
            if (preOut) begin
                // total count is a*(p+1) + (b-a)*p = b*p + a
                if (bCnt_q <= 13'h0001) begin
                    aCnt_q    <= aPreset;
                    bCnt_q    <= bPreset;
                    fbPulse_q <= 1'b1;
                end else begin
                    bCnt_q <= bCnt_q - 13'h0001;
                    if (aCnt_q != 5'h00) begin
                        aCnt_q <= aCnt_q - 5'h01;
                    end
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // reference divider
    // ----------------------------------------------------------------
    reg [13:0] rCnt_q;
    reg        refPulse_q;

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rCnt_q     <= 14'h0000;
            refPulse_q <= 1'b0;
        end else if (divHold) begin
            rCnt_q     <= 14'h0000;
            refPulse_q <= 1'b0;
        end else begin
            refPulse_q <= 1'b0;
            if (refRise) begin
                // ratio 0 is treated as 1 rather than stalling
                if (rCnt_q + 14'h0001 >= rPreset) begin
                    rCnt_q     <= 14'h0000;
                    refPulse_q <= 1'b1;
                end else begin
                    rCnt_q <= rCnt_q + 14'h0001;
                end
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    reg observe_d;

    always @* begin
        case (muxSel)
            `SDSL_MUX_LOCK:   observe_d = lock_q[1];
            `SDSL_MUX_FBDIV:  observe_d = fbPulse_q;
            `SDSL_MUX_REFDIV: observe_d = refPulse_q;
            default:          observe_d = 1'b0;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            observe_output      <= 1'b0;
            pumpOutputEnable    <= 1'b0;
            ref_series_switch_a <= 1'b0;
            ref_series_switch_b <= 1'b0;
            ref_shunt_switch    <= 1'b1;
            powerDown           <= 1'b1;
        end else begin
            observe_output      <= observe_d;
            pumpOutputEnable    <= ~powerDown_d &
                                   ~ctrlLatch_q[`SDSL_TRISTATE_BIT];
            ref_series_switch_a <= ~powerDown_d;
            ref_series_switch_b <= ~powerDown_d;
            ref_shunt_switch    <= powerDown_d;
            powerDown           <= powerDown_d;
        end
    end

endmodule // sdsl_synth

// file: sdsl_consts.vh
// constants for the synthesizer divider and serial load block
// assumes one 250 MHz system clock; all pins enter unsynchronised
`ifndef SDSL_CONSTS_VH
`define SDSL_CONSTS_VH

// ----------------------------------------------------------------
// serial word
// ----------------------------------------------------------------
`define SDSL_WORD_W       24
`define SDSL_SEL_HI       1
`define SDSL_SEL_LO       0
`define SDSL_SEL_CONTROL  2'h0
`define SDSL_SEL_REFDIV   2'h1
`define SDSL_SEL_FEEDBACK 2'h2
`define SDSL_SEL_TEST     2'h3

// ----------------------------------------------------------------
// control latch fields
// ----------------------------------------------------------------
`define SDSL_PRE_HI       23
`define SDSL_PRE_LO       22
`define SDSL_PD2_BIT      21
`define SDSL_PD1_BIT      20
`define SDSL_TRISTATE_BIT 9
`define SDSL_MUX_HI       7
`define SDSL_MUX_LO       5
`define SDSL_CRESET_BIT   4

// ----------------------------------------------------------------
// divider latch fields
// ----------------------------------------------------------------
`define SDSL_B_HI         20
`define SDSL_B_LO         8
`define SDSL_A_HI         6
`define SDSL_A_LO         2
`define SDSL_R_HI         15
`define SDSL_R_LO         2

// ----------------------------------------------------------------
// prescaler and observe encodings
// ----------------------------------------------------------------
`define SDSL_PRE_8        2'h0
`define SDSL_PRE_16       2'h1
`define SDSL_MOD_8        6'h08
`define SDSL_MOD_16       6'h10
`define SDSL_MOD_32       6'h20
`define SDSL_MUX_LOCK     3'h1
`define SDSL_MUX_FBDIV    3'h2
`define SDSL_MUX_REFDIV   3'h4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SDSL_RST_WORD     24'h000000
`define SDSL_RST_B        13'h0003
`define SDSL_RST_R        14'h0001

`endif

// file: sdsl_asserts.sv
// pin checks for the synthesizer digital section
// assumes one clock domain, bound to sdsl_synth from the bench
`timescale 1ns/1ps
module sdsl_asserts (
    input wire clk_sys,
    input wire reset_n,
    input wire chipEnable,
    input wire powerDown,
    input wire pumpOutputEnable,
    input wire ref_series_switch_a,
    input wire ref_series_switch_b,
    input wire ref_shunt_switch
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    sequence ceLowHeld;
        !chipEnable [*4];
    endsequence
    sequence refIsolated;
        !ref_series_switch_a && !ref_series_switch_b && ref_shunt_switch;
    endsequence
    sequence refConnected;
        ref_series_switch_a && ref_series_switch_b && !ref_shunt_switch;
    endsequence
    a_ce_down_fast: assert property (
        $fell(chipEnable) |-> ##[1:4] powerDown)
        else $error("pin low did not power down");
    a_ce_down_held: assert property (ceLowHeld |=> powerDown)
        else $error("powered while pin low");
    a_pump_hiz_ce: assert property (ceLowHeld |=> !pumpOutputEnable)
        else $error("pump driven while pin low");
    a_pump_off_pd: assert property (powerDown |-> !pumpOutputEnable)
        else $error("pump driven in power down");
    a_ref_isolated: assert property (powerDown |-> refIsolated)
        else $error("reference loaded in power down");
    a_ref_isolated_ce: assert property (ceLowHeld |=> refIsolated)
        else $error("reference not isolated");
    a_ref_connected: assert property (!powerDown |-> refConnected)
        else $error("switches wrong while powered");
    a_up_needs_ce: assert property (
        $fell(powerDown) |-> $past(chipEnable, 2))
        else $error("powered up with pin low");
endmodule // sdsl_asserts

// file: sdsl_host.sv
// host model driving the three-wire serial port
// assumes the bench calls sendWord between clk_sys falling edges
`timescale 1ns/1ps
module sdsl_host (
    input  wire clk_sys,
    output reg  serialClock,
    output reg  serialData,
    output reg  load_strobe
);
    initial begin
        serialClock = 1'b0;
        serialData  = 1'b0;
        load_strobe = 1'b0;
    end
    // clock idles low outside frames; data shows the inverse after hold
    task automatic sendWord(input [23:0] w);
        integer i;
        begin
            for (i = 23; i >= 0; i = i - 1) begin
                serialData = w[i];
                repeat (3) @(negedge clk_sys);
                serialClock = 1'b1;
                repeat (7) @(negedge clk_sys);
                serialClock = 1'b0;
                repeat (4) @(negedge clk_sys);
            end
            serialData = ~w[0];
            repeat (3) @(negedge clk_sys);
            load_strobe = 1'b1;
            repeat (6) @(negedge clk_sys);
            load_strobe = 1'b0;
            repeat (3) @(negedge clk_sys);
        end
    endtask
endmodule // sdsl_host

// file: sdsl_synth_bench.sv
// self-checking bench for sdsl_synth
// assumes a host model for the serial port and slow vco/reference pins
`timescale 1ns/1ps
module sdsl_synth_bench;
    reg     clk_sys = 1'b0;
    reg     reset_n = 1'b0;
    reg     chipEnable = 1'b1;
    reg     reference_input = 1'b0;
    reg     vcoInput = 1'b0;
    reg     lockDetectIn = 1'b0;
    wire    serialClock, serialData, load_strobe, observe_output;
    wire    pumpOutputEnable, powerDown;
    wire    ref_series_switch_a, ref_series_switch_b, ref_shunt_switch;
    integer n_fail = 0;
    integer n_tests = 0;
    always #2 clk_sys = ~clk_sys;
    // vco period 6 clk, reference period 10 clk: both well under clk/2
    always begin
        repeat (3) @(negedge clk_sys);
        vcoInput = ~vcoInput;
    end
    always begin
        repeat (5) @(negedge clk_sys);
        reference_input = ~reference_input;
    end
    sdsl_host u_host (.clk_sys(clk_sys), .serialClock(serialClock),
        .serialData(serialData), .load_strobe(load_strobe));
    sdsl_synth u_dut (.clk_sys(clk_sys), .reset_n(reset_n),
        .serialClock(serialClock), .serialData(serialData),
        .load_strobe(load_strobe), .chipEnable(chipEnable),
        .reference_input(reference_input), .vcoInput(vcoInput),
        .lockDetectIn(lockDetectIn), .observe_output(observe_output),
        .pumpOutputEnable(pumpOutputEnable), .powerDown(powerDown),
        .ref_series_switch_a(ref_series_switch_a),
        .ref_series_switch_b(ref_series_switch_b),
        .ref_shunt_switch(ref_shunt_switch));
    task results;
        begin
            $display("tests %0d fails %0d", n_tests, n_fail);
            if (n_fail == 0 && n_tests > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    task chk(input logic ok, input string m);
        begin
            n_tests = n_tests + 1;
            if (ok !== 1'b1) begin
                n_fail = n_fail + 1;
                $display("[ERR] %0t %s", $time, m);
            end
        end
    endtask
    task ctl(input [1:0] p, input pd1, input [2:0] mux);
        u_host.sendWord({p, 1'b0, pd1, 12'h000, mux, 3'h0, 2'h0});
    endtask
    // cycles from one observe pulse to the next, bounded
    task waitPulse(output integer n);
        begin
            n = 0;
            @(negedge clk_sys);
            while (observe_output !== 1'b1 && n < 8000) begin
                @(negedge clk_sys);
                n = n + 1;
            end
            if (n >= 8000) begin
                chk(1'b0, "no pulse");
                results;
            end
        end
    endtask
    // presets reload at terminal count, so the second pulse-to-pulse gap is measured
    task gap(input integer exp);
        integer n;
        begin
            repeat (3) waitPulse(n);
            chk(n + 1 == exp, "pulse spacing");
        end
    endtask
    task tFb(input [1:0] p, input [12:0] b, input [4:0] a, input integer m);
        begin
            ctl(p, 1'b0, 3'h2);
            u_host.sendWord({3'h0, b, 1'h0, a, 2'h2});
            gap((m * b + a) * 6);
        end
    endtask
    task tReset;
        begin
            repeat (19) @(negedge clk_sys);
            chk(powerDown === 1'b1 && ref_shunt_switch === 1'b1, "rst");
            @(negedge clk_sys);
            reset_n = 1'b1;
            repeat (4) @(negedge clk_sys);
        end
    endtask
    task tPowerUp;
        begin
            u_host.sendWord({8'h00, 14'h0004, 2'h1});
            ctl(2'h0, 1'b0, 3'h4);
            u_host.sendWord({3'h0, 13'h0007, 1'h0, 5'h00, 2'h2});
            chk(pumpOutputEnable === 1'b1 && powerDown === 1'b0, "up");
            gap(40);
        end
    endtask
    // counter reset holds the dividers: a broken hold would pulse every 40
    task tHold;
        integer k;
        integer seen;
        begin
            u_host.sendWord(24'h000090);
            seen = 0;
            for (k = 0; k < 200; k = k + 1) begin
                @(negedge clk_sys);
                if (observe_output !== 1'b0) begin
                    seen = seen + 1;
                end
            end
            chk(seen == 0, "held");
            u_host.sendWord(24'h000080);
            gap(40);
        end
    endtask
    // three-state bit alone must not power the part down
    task tPumpOff;
        begin
            u_host.sendWord(24'h000240);
            chk(pumpOutputEnable === 1'b0 && powerDown === 1'b0, "hiz");
            ctl(2'h0, 1'b0, 3'h2);
            repeat (4) @(negedge clk_sys);
            chk(pumpOutputEnable === 1'b1, "pump back");
        end
    endtask
    task tLock;
        begin
            ctl(2'h0, 1'b0, 3'h1);
            lockDetectIn = 1'b1;
            repeat (6) @(negedge clk_sys);
            chk(observe_output === 1'b1, "lock high");
            lockDetectIn = 1'b0;
            repeat (6) @(negedge clk_sys);
            chk(observe_output === 1'b0, "lock low");
        end
    endtask
    task tChipEnable;
        begin
            chipEnable = 1'b0;
            repeat (6) @(negedge clk_sys);
            chk(powerDown === 1'b1 && pumpOutputEnable === 1'b0, "ce");
            chk(ref_series_switch_a === 1'b0 && ref_series_switch_b === 1'b0
                && ref_shunt_switch === 1'b1, "switches");
            chipEnable = 1'b1;
            repeat (6) @(negedge clk_sys);
            chk(powerDown === 1'b0, "ce up");
        end
    endtask
    task tSoftDown;
        begin
            ctl(2'h0, 1'b1, 3'h0);
            chk(powerDown === 1'b1, "soft down");
            chk(observe_output === 1'b0, "mux off");
            u_host.sendWord(24'h000003);
            chk(powerDown === 1'b1, "test latch");
        end
    endtask
    initial begin
        tReset;
        tPowerUp;
        // ratios kept at or above p*p-p, vco far below the counter limit
        tFb(2'h0, 13'h0007, 5'h00, 8);
        tFb(2'h1, 13'h000F, 5'h01, 16);
        tFb(2'h2, 13'h001F, 5'h1F, 32);
        tHold;
        tPumpOff;
        tLock;
        tChipEnable;
        tSoftDown;
        results;
    end
endmodule // sdsl_synth_bench
bind sdsl_synth sdsl_asserts u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
    .chipEnable(chipEnable), .powerDown(powerDown),
    .pumpOutputEnable(pumpOutputEnable),
    .ref_series_switch_a(ref_series_switch_a),
    .ref_series_switch_b(ref_series_switch_b),
    .ref_shunt_switch(ref_shunt_switch));
